// ---- hdl/event_bus_mux.sv ----
// event bus multiplexer tree: load/store merge, two unit muxes and four
// byte-lane muxes producing the 32-bit monitor event bus.
// assumes: unit buses already carry the documented encodings.
`timescale 1ns/1ps
`default_nettype none
module event_bus_mux
    import perf_chain_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire mon_ctrl_t    ctrl_i,
    input  wire unit_events_t units_i,
    output logic [31:0]       event_bus_o
);

    logic [31:0] lsu_bus;
    logic [31:0] mux_zero;
    logic [31:0] mux_one;
    logic [31:0] next_bus;

    // byte 0 is documented bits 0:7, i.e. [31:24] here
    function automatic logic [7:0] lane(input logic [31:0] b,
                                        input int i);
        return b[31-8*i -: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lsu
            logic [7:0] b_byte;
            // extra unit-b bits replace lanes 2,3 when selected; the
            // lanes are split at elaboration so no index leaves the field
            if (g >= 2) begin : g_extra
                assign b_byte = (ctrl_i.lsu_extra_select != 2'h0)
                    ? units_i.lsu_b_extra[15-8*(g-2) -: 8]
                    : lane(units_i.load_store_unit_b, g);
            end else begin : g_base
                assign b_byte = lane(units_i.load_store_unit_b, g);
            end
            assign lsu_bus[31-8*g -: 8] = ctrl_i.lsu_byte_from_b[g] ?
                b_byte : lane(units_i.load_store_unit_a, g);
        end
    endgenerate

    always_comb begin
        case (ctrl_i.unit_mux_zero_sel)
            2'h0:    mux_zero = units_i.fpu;
            2'h1:    mux_zero = units_i.issue_unit;
            2'h2:    mux_zero = {16'h0000, units_i.fetch_unit[15:12], 12'h000};
            default: mux_zero = units_i.fixed_point_unit;
        endcase
    end

    always_comb begin
        case (ctrl_i.unit_mux_one_sel)
            2'h0:    mux_one = {units_i.decode_unit[31:16], 16'h0000};
            2'h2:    mux_one = units_i.issue_unit;
            default: mux_one = units_i.fixed_point_unit;
        endcase
    end

    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [1:0] s;
            assign s = ctrl_i.lane_source_select[7-2*g -: 2];
            always_comb begin
                if (s[1]) begin
                    next_bus[31-8*g -: 8] = lane(lsu_bus, g);
                end else if (s[0]) begin
                    next_bus[31-8*g -: 8] = lane(mux_one, g);
                end else begin
                    next_bus[31-8*g -: 8] = lane(mux_zero, g);
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            event_bus_o <= 32'h0000_0000;
        end else begin
            event_bus_o <= next_bus;
        end
    end

    property p_fpu_path;
        @(posedge mclk_i) disable iff (rst_i)
        (ctrl_i.unit_mux_zero_sel == 2'h0 &&
         ctrl_i.lane_source_select[7:6] == 2'h0)
        |=> event_bus_o[31:24] == $past(units_i.fpu[31:24]);
    endproperty
    a_fpu_path: assert property (p_fpu_path)
        else $error("fpu lane 0 not routed");

endmodule
`default_nettype wire

// ---- hdl/perf_chain_pkg.sv ----
// package: constants and carrier types for the event counter chain and
// the event bus multiplexer tree.
// assumes: bit 0 of every documented field is the most significant bit.
package perf_chain_pkg;

    localparam int        NUM_CTR     = 8;
    localparam int        CTR_W       = 32;
    localparam logic [4:0] SEL_OVF    = 5'h0A;
    localparam logic [4:0] SEL_SPEC_A = 5'h0B;
    localparam logic [4:0] SEL_SPEC_B = 5'h0C;
    localparam logic [31:0] CTR_RESET = 32'h0000_0000;
    localparam logic [1:0] MUX_RESET  = 2'h0;
    localparam int        SPEC_CTR_LO = 4;
    localparam int        SPEC_CTR_HI = 6;

    // speculative category codes (counter index, select code, control 62:63)
    typedef enum logic [3:0] {
        CAT_NONE      = 4'b0000,
        CAT_LSU       = 4'b0001,
        CAT_FXU       = 4'b0010,
        CAT_DMISS     = 4'b0011,
        CAT_FPU       = 4'b0100,
        CAT_FXU_LONG  = 4'b0101,
        CAT_REJECT    = 4'b0110,
        CAT_FPU_LONG  = 4'b0111,
        CAT_IMISS_GE  = 4'b1000,
        CAT_XLATE_REJ = 4'b1001,
        CAT_MISP_GE   = 4'b1010
    } spec_cat_t;

    typedef enum logic [1:0] {
        SPEC_IDLE = 2'b00,
        SPEC_RUN  = 2'b01
    } spec_state_t;

    // monitor_ctrl_one fields that steer the bus tree and speculation
    typedef struct packed {
        logic [1:0] unit_mux_zero_sel;   // bits 0:1
        logic [1:0] unit_mux_one_sel;    // bits 3:4
        logic [1:0] lsu_extra_select;    // bits 9:10
        logic [3:0] lsu_byte_from_b;     // per byte: 1 takes unit b
        logic [7:0] lane_source_select;  // bits 12:19, lane 0 first
        logic [1:0] spec_mode;           // bits 62:63
    } mon_ctrl_t;

    // unit event buses; bit 0 of the documented bus is [31] here
    typedef struct packed {
        logic [31:0] fpu;
        logic [31:0] fetch_unit;
        logic [31:0] decode_unit;
        logic [31:0] issue_unit;
        logic [31:0] fixed_point_unit;
        logic [31:0] load_store_unit_a;
        logic [31:0] load_store_unit_b;
        logic [15:0] lsu_b_extra;        // documented bits 48:63
    } unit_events_t;

    typedef struct packed {
        logic       stall_begin;  // next_to_complete stops or table empty
        logic       finish;       // a group finished, category valid
        spec_cat_t  category;     // category of the last finished event
    } spec_events_t;

endpackage

// ---- hdl/perf_counter_chain.sv ----
// eight chainable 32-bit event counters, speculative counting on
// counters 5 and 7 with backup registers, and the event bus tree.
// assumes: count_i pulses come from the per-counter event selection.
// Notes on behaviour
// - next counter with overflow code extends lower
// - chain wraps: counter 1 extends counter 8
// - up to eight counters chain, 256 bits
// - lower chained counter never raises exception
// - topmost raises on bit 0, proper enable
// - counters 5,7 have backups; mode nonzero, code
// - speculation begins on completion stop or empty
// - matching finish commits count into backup
// - mismatch restores count from backup
// - speculative exception uses backup sign bit
// - category decoded from code and mode bits
// - carry upward only from committed values
// - load/store buses merged per byte
// - extra unit-b bits selected by bits 9:10
// - two unit muxes choose non-load/store source
// - four lane muxes pick first-level outputs
// - floating unit on selects 00 and 00
// - lane select 1x routes load/store bus
// - fetch unit: bits 16:19 source, 0:15 idle
// - decode unit: occupancy bits, full, idle
// - overflow code counts previous counter's overflows
`timescale 1ns/1ps
`default_nettype none
module perf_counter_chain
    import perf_chain_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    input  wire logic [39:0]   counter_event_select_i, // 5 bits each, ctr1 high
    input  wire logic [7:0]    count_i,          // ctr1 is bit 0
    input  wire logic          first_counter_cond_enable_i,
    input  wire logic          other_counter_cond_enable_i,
    input  wire mon_ctrl_t     monitor_ctrl_one_i,
    input  wire unit_events_t  units_i,
    input  wire spec_events_t  spec_i,
    output logic [255:0]       event_counter_o,  // ctr1 in [31:0]
    output logic [7:0]         neg_cond_o,
    output logic [31:0]        event_bus_o
);

    logic [CTR_W-1:0] ctr    [NUM_CTR];
    logic [CTR_W-1:0] backup [2];
    logic [NUM_CTR-1:0] ovf_mode;
    logic [NUM_CTR-1:0] wrap;       // committed wrap of counter i
    logic [NUM_CTR-1:0] inc;
    logic [NUM_CTR-1:0] spec_en;
    logic [NUM_CTR-1:0] speculating;
    spec_state_t        spec_state [2];
    spec_cat_t          spec_cat   [2];

    function automatic logic [4:0] sel_of(input int i);
        return counter_event_select_i[39-5*i -: 5];
    endfunction

    // maps a speculative counter and its settings onto a category
    function automatic spec_cat_t decode_cat(input logic hi_ctr,
                                             input logic [4:0] code,
                                             input logic [1:0] mode);
        spec_cat_t c;
        c = CAT_NONE;
        if (code == SEL_SPEC_A) begin
            case (mode)
                2'h1:    c = hi_ctr ? CAT_FPU      : CAT_LSU;
                2'h2:    c = hi_ctr ? CAT_FXU_LONG : CAT_FXU;
                2'h3:    c = hi_ctr ? CAT_REJECT   : CAT_DMISS;
                default: c = CAT_NONE;
            endcase
        end else if (code == SEL_SPEC_B) begin
            case (mode)
                2'h1:    c = hi_ctr ? CAT_XLATE_REJ : CAT_FPU_LONG;
                2'h2:    c = hi_ctr ? CAT_MISP_GE   : CAT_IMISS_GE;
                default: c = CAT_NONE;
            endcase
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NUM_CTR; g++) begin : g_ctr
            localparam int LOWER = (g + NUM_CTR - 1) % NUM_CTR;
            localparam int UPPER = (g + 1) % NUM_CTR;
            localparam int SI    = (g == SPEC_CTR_HI) ? 1 : 0;
            assign ovf_mode[g] = (sel_of(g) == SEL_OVF);
            assign inc[g] = ovf_mode[g] ? wrap[LOWER] : count_i[g];
            if (g == SPEC_CTR_LO || g == SPEC_CTR_HI) begin : g_spec
                assign spec_en[g] = (monitor_ctrl_one_i.spec_mode != 2'h0)
                    && (sel_of(g) == SEL_SPEC_A || sel_of(g) == SEL_SPEC_B);
                assign speculating[g] = spec_state[SI] == SPEC_RUN;
                // only committed values carry upward, so the wrap is seen
                // when the backup itself passes all ones
                assign wrap[g] = spec_en[g]
                    ? (speculating[g] && spec_i.finish
                       && spec_i.category == spec_cat[SI]
                       && ctr[g] < backup[SI])
                    : (inc[g] && ctr[g] == 32'hFFFF_FFFF);
            end else begin : g_plain
                assign spec_en[g]     = 1'b0;
                assign speculating[g] = 1'b0;
                assign wrap[g] = inc[g] && ctr[g] == 32'hFFFF_FFFF;
            end

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    ctr[g] <= CTR_RESET;
                end else if (spec_en[g] && speculating[g] && spec_i.finish
                             && spec_i.category != spec_cat[SI]) begin
                    ctr[g] <= backup[SI];
                end else if (inc[g]) begin
                    ctr[g] <= ctr[g] + 32'h0000_0001;
                end
            end

            logic en_bit;
            logic sign_bit;
            assign en_bit = (g == 0) ? first_counter_cond_enable_i
                                     : other_counter_cond_enable_i;
            assign sign_bit = spec_en[g] ? backup[SI][31] : ctr[g][31];
            // a chained lower counter is silent; the top one reports
            assign neg_cond_o[g] = en_bit && sign_bit && !ovf_mode[UPPER];
            assign event_counter_o[32*g +: 32] = ctr[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // speculation control for counters 5 and 7
    generate
        for (g = 0; g < 2; g++) begin : g_bk
            localparam int CI = (g == 0) ? SPEC_CTR_LO : SPEC_CTR_HI;
            logic matched;
            assign matched = spec_i.finish && spec_i.category == spec_cat[g];

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    spec_cat[g] <= CAT_NONE;
                end else begin
                    spec_cat[g] <= decode_cat(g == 1, sel_of(CI),
                                              monitor_ctrl_one_i.spec_mode);
                end
            end

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    spec_state[g] <= SPEC_IDLE;
                end else begin
                    case (spec_state[g])
                        SPEC_IDLE: begin
                            if (spec_en[CI] && spec_i.stall_begin) begin
                                spec_state[g] <= SPEC_RUN;
                            end
                        end
                        SPEC_RUN: begin
                            if (!spec_en[CI] || spec_i.finish) begin
                                spec_state[g] <= SPEC_IDLE;
                            end
                        end
                        default: spec_state[g] <= SPEC_IDLE;
                    endcase
                end
            end

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    backup[g] <= CTR_RESET;
                end else if (!spec_en[CI]) begin
                    backup[g] <= ctr[CI];
                end else if (spec_state[g] == SPEC_RUN && matched) begin
                    backup[g] <= inc[CI] ? ctr[CI] + 32'h0000_0001
                                         : ctr[CI];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    event_bus_mux u_bus (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .ctrl_i      (monitor_ctrl_one_i),
        .units_i     (units_i),
        .event_bus_o (event_bus_o)
    );

    ////////////////////////////////////////////////////////////////////////
    sequence s_lower_wraps;
        ctr[0] == 32'hFFFF_FFFF && count_i[0] && !ovf_mode[0];
    endsequence

    property p_chain_carry;
        @(posedge mclk_i) disable iff (rst_i)
        s_lower_wraps and ovf_mode[1] ##0 1'b1
        |=> ctr[1] == $past(ctr[1]) + 32'h0000_0001 && ctr[0] == 32'h0;
    endproperty
    a_chain_carry: assert property (p_chain_carry)
        else $error("upper counter missed carry");

    property p_wrap_chain;
        @(posedge mclk_i) disable iff (rst_i)
        ovf_mode[0] && wrap[7] |=> ctr[0] == $past(ctr[0]) + 32'h0000_0001;
    endproperty
    a_wrap_chain: assert property (p_wrap_chain)
        else $error("counter 1 missed carry from counter 8");

    property p_lower_silent;
        @(posedge mclk_i) disable iff (rst_i)
        ovf_mode[1] |-> !neg_cond_o[0];
    endproperty
    a_lower_silent: assert property (p_lower_silent)
        else $error("chained lower counter raised exception");

    property p_top_raises;
        @(posedge mclk_i) disable iff (rst_i)
        !ovf_mode[2] && other_counter_cond_enable_i && ctr[1][31]
        |-> neg_cond_o[1];
    endproperty
    a_top_raises: assert property (p_top_raises)
        else $error("top counter failed to raise exception");

    property p_spec_start;
        @(posedge mclk_i) disable iff (rst_i)
        spec_state[0] == SPEC_IDLE && spec_en[4] && spec_i.stall_begin
        |=> spec_state[0] == SPEC_RUN;
    endproperty
    a_spec_start: assert property (p_spec_start)
        else $error("speculation did not begin");

    property p_restore;
        @(posedge mclk_i) disable iff (rst_i)
        spec_en[4] && speculating[4] && spec_i.finish
        && spec_i.category != spec_cat[0]
        |=> ctr[4] == $past(backup[0]);
    endproperty
    a_restore: assert property (p_restore)
        else $error("counter 5 not restored from backup");

    property p_commit;
        @(posedge mclk_i) disable iff (rst_i)
        spec_en[6] && speculating[6] && spec_i.finish
        && spec_i.category == spec_cat[1] && !inc[6]
        |=> backup[1] == ctr[6];
    endproperty
    a_commit: assert property (p_commit)
        else $error("counter 7 commit missing");

    property p_spec_sign;
        @(posedge mclk_i) disable iff (rst_i)
        spec_en[4] && !ovf_mode[5] && other_counter_cond_enable_i
        |-> neg_cond_o[4] == backup[0][31];
    endproperty
    a_spec_sign: assert property (p_spec_sign)
        else $error("speculative exception not from backup sign");

    sequence s_match_lo;
        spec_en[4] && speculating[4] && spec_i.finish
        && spec_i.category == spec_cat[0];
    endsequence

    property p_commit_lo;
        @(posedge mclk_i) disable iff (rst_i)
        s_match_lo ##0 !inc[4] |=> backup[0] == ctr[4];
    endproperty
    a_commit_lo: assert property (p_commit_lo)
        else $error("counter 5 commit missing");

    property p_restore_hi;
        @(posedge mclk_i) disable iff (rst_i)
        spec_en[6] && speculating[6] && spec_i.finish
        && spec_i.category != spec_cat[1]
        |=> ctr[6] == $past(backup[1]);
    endproperty
    a_restore_hi: assert property (p_restore_hi)
        else $error("counter 7 not restored from backup");

    // a speculative counter carries upward only at a commit
    property p_no_spec_carry;
        @(posedge mclk_i) disable iff (rst_i)
        spec_en[4] && !(speculating[4] && spec_i.finish) |-> !wrap[4];
    endproperty
    a_no_spec_carry: assert property (p_no_spec_carry)
        else $error("carry from a speculative value");

    property p_spec_enable;
        @(posedge mclk_i) disable iff (rst_i)
        monitor_ctrl_one_i.spec_mode == 2'h0 |-> !spec_en[4] && !spec_en[6];
    endproperty
    a_spec_enable: assert property (p_spec_enable)
        else $error("speculation enabled with mode zero");

    property p_idle_when_off;
        @(posedge mclk_i) disable iff (rst_i)
        !spec_en[6] |=> spec_state[1] == SPEC_IDLE;
    endproperty
    a_idle_when_off: assert property (p_idle_when_off)
        else $error("counter 7 speculating while disabled");

    property p_mid_carry;
        @(posedge mclk_i) disable iff (rst_i)
        ovf_mode[2] && wrap[1] |=> ctr[2] == $past(ctr[2]) + 32'h0000_0001;
    endproperty
    a_mid_carry: assert property (p_mid_carry)
        else $error("counter 3 missed carry from counter 2");


endmodule
`default_nettype wire

// ---- test/exec_units_model.sv ----
// partner model: execution units driving fresh random event buses.
// assumes: one new set of unit buses per clock, all zero in reset.
`timescale 1ns/1ps
`default_nettype none
module exec_units_model
    import perf_chain_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    output var unit_events_t  units_o
);
    logic [255:0] r;

    // new values every cycle so a stale bus never passes for a match
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            units_o <= '0;
        end else begin
            for (int k = 0; k < 8; k++) begin
                r[32*k +: 32] = $urandom;
            end
            units_o <= r[239:0];
        end
    end
endmodule
`default_nettype wire

// ---- test/perf_counter_chain_tb.sv ----
// testbench: counter chain, speculative counters and event bus tree.
// assumes: counters stay far from wrap, so exceptions stay low.
`timescale 1ns/1ps
`default_nettype none
module perf_counter_chain_tb
    import perf_chain_pkg::*;
;
    logic         mclk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic [39:0]  sel = '0;
    logic [7:0]   cnt = '0;
    logic         ce1 = 1'b0;
    logic         cej = 1'b0;
    mon_ctrl_t    ctrl = '0;
    spec_events_t spec = '0;
    unit_events_t units;
    logic [255:0] ctr_o;
    logic [7:0]   neg_o;
    logic [31:0]  bus_o;
    logic [31:0]  exp_ctr [8];
    logic [63:0]  exp_bus = '0;
    bit           chk_on = 1'b0;
    int           fails = 0;
    int           cmp_count = 0;

    always #5 mclk_i = ~mclk_i;

    exec_units_model units_src (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .units_o (units)
    );

    perf_counter_chain uut (
        .mclk_i                      (mclk_i),
        .rst_i                       (rst_i),
        .counter_event_select_i      (sel),
        .count_i                     (cnt),
        .first_counter_cond_enable_i (ce1),
        .other_counter_cond_enable_i (cej),
        .monitor_ctrl_one_i          (ctrl),
        .units_i                     (units),
        .spec_i                      (spec),
        .event_counter_o             (ctr_o),
        .neg_cond_o                  (neg_o),
        .event_bus_o                 (bus_o)
    );

    ////////////////////////////////////////
    task automatic check32(input string what, input logic [31:0] seen,
                           input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic bit ovf(input logic [39:0] s, input int i);
        return s[39-5*i -: 5] === SEL_OVF;
    endfunction

    // upper word = mask of checked bits, lower word = expected value
    function automatic logic [63:0] bus_exp(input mon_ctrl_t c,
                                            input unit_events_t u);
        logic [63:0] m0, m1, ls, s, r;
        logic [31:0] b;
        case (c.unit_mux_zero_sel)
            2'h0:    m0 = {32'hFFFF_FFFF, u.fpu};
            2'h1:    m0 = {32'hFFFF_FFFF, u.issue_unit};
            2'h2:    m0 = {48'hFFFF_F000_0000, u.fetch_unit[15:12], 12'h000};
            default: m0 = {32'hFFFF_FFFF, u.fixed_point_unit};
        endcase
        case (c.unit_mux_one_sel)
            2'h0:    m1 = {32'hFFFF_FFFF, u.decode_unit[31:16], 16'h0000};
            2'h2:    m1 = {32'hFFFF_FFFF, u.issue_unit};
            default: m1 = {32'hFFFF_FFFF, u.fixed_point_unit};
        endcase
        b = u.load_store_unit_b;
        if (c.lsu_extra_select != 2'h0) begin
            b[15:0] = u.lsu_b_extra;
        end
        ls = {32'hFFFF_FFFF, u.load_store_unit_a};
        for (int g = 0; g < 4; g++) begin
            if (c.lsu_byte_from_b[g]) begin
                ls[31-8*g -: 8] = b[31-8*g -: 8];
            end
            case (c.lane_source_select[7-2*g -: 2])
                2'h0:    s = m0;
                2'h1:    s = m1;
                default: s = ls;
            endcase
            r[63-8*g -: 8] = s[63-8*g -: 8];
            r[31-8*g -: 8] = s[31-8*g -: 8];
        end
        return r;
    endfunction

    function automatic spec_cat_t spec_cat(input int c, input logic [4:0] code,
                                           input logic [1:0] m);
        if (m == 2'h0) return CAT_NONE;
        if (code == SEL_SPEC_A) return spec_cat_t'((c == 4 ? 4'h0 : 4'h3) + m);
        if (m == 2'h3) return CAT_NONE;
        return spec_cat_t'((c == 4 ? 4'h6 : 4'h8) + m);
    endfunction

    // carries ripple round the ring, so settle it over eight passes
    task automatic step_ctrs();
        logic [7:0] inc, wrap;
        inc = '0;
        wrap = '0;
        repeat (8) begin
            for (int i = 0; i < 8; i++) begin
                inc[i] = ovf(sel, i) ? wrap[(i+7)%8] : cnt[i];
                wrap[i] = inc[i] && (exp_ctr[i] == 32'hFFFF_FFFF);
            end
        end
        for (int i = 0; i < 8; i++) begin
            exp_ctr[i] = exp_ctr[i] + inc[i];
        end
    endtask

    always @(posedge mclk_i) begin
        if (!rst_i) begin
            exp_bus <= bus_exp(ctrl, units);
            step_ctrs();
        end
    end

    always @(negedge mclk_i) begin
        if (chk_on) begin
            for (int i = 0; i < 8; i++) begin
                check32("counter", ctr_o[32*i +: 32], exp_ctr[i]);
            end
            check32("event bus", bus_o & exp_bus[63:32], exp_bus[31:0]);
            check32("exception", {24'h0, neg_o}, 32'h0);
        end
    end

    ////////////////////////////////////////
    task automatic do_reset();
        chk_on = 1'b0;
        rst_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            check32("reset counter", ctr_o[32*i +: 32], 32'h0);
            exp_ctr[i] = '0;
        end
        check32("reset bus", bus_o, 32'h0);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk_on = 1'b1;
        $display("test reset done");
    endtask

    task automatic rand_phase(input int n);
        logic [39:0] s;
        logic [31:0] w;
        repeat (n) begin
            for (int i = 0; i < 8; i++) begin
                s[39-5*i -: 5] = ($urandom_range(3) == 0) ? SEL_OVF : 5'h04;
            end
            if (s == {8{SEL_OVF}}) s[39:35] = 5'h01;
            w = $urandom;
            @(posedge mclk_i);
            sel <= s;
            cnt <= w[7:0];
            ce1 <= w[8];
            cej <= w[9];
            ctrl <= w[31:12];
            spec <= spec_events_t'({w[10], w[11], w[3:0]});
        end
        $display("test random traffic done");
    endtask

    task automatic spec_phase(input int c, input spec_cat_t cat, input int k);
        @(posedge mclk_i);
        spec.stall_begin <= 1'b1;
        @(posedge mclk_i);
        spec.stall_begin <= 1'b0;
        cnt[c] <= 1'b1;
        repeat (k) @(posedge mclk_i);
        cnt[c] <= 1'b0;
        spec.finish <= 1'b1;
        spec.category <= cat;
        @(posedge mclk_i);
        spec.finish <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic spec_case(input int c, input logic [4:0] code,
                             input logic [1:0] mode);
        logic [39:0] s;
        logic [31:0] v;
        spec_cat_t   cat;
        v = exp_ctr[c];
        cat = spec_cat(c, code, mode);
        s = {8{5'h04}};
        s[39-5*c -: 5] = code;
        @(posedge mclk_i);
        sel <= s;
        ctrl.spec_mode <= mode;
        repeat (4) @(posedge mclk_i);
        spec_phase(c, cat, 3);
        check32("spec commit", ctr_o[32*c +: 32], v + 32'd3);
        spec_phase(c, (cat == CAT_LSU) ? CAT_FXU : CAT_LSU, 5);
        v = (mode == 2'h0) ? v + 32'd8 : v + 32'd3;
        check32("spec restore", ctr_o[32*c +: 32], v);
        check32("spec exception", {24'h0, neg_o}, 32'h0);
        exp_ctr[c] = v;
        $display("test spec counter %0d code %h mode %h done", c + 1, code, mode);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // guard against a hung run
    initial begin
        #200_000;
        fails++;
        $display("unexpected run length: limit reached");
        final_report();
    end

    initial begin
        void'($urandom(32'h7114B741));
        do_reset();
        rand_phase(400);
        // two rings: seven uppers over counter 1, then over counter 8
        @(posedge mclk_i);
        sel <= {5'h01, {7{SEL_OVF}}};
        cnt <= 8'hFF;
        repeat (20) @(posedge mclk_i);
        sel <= {{7{SEL_OVF}}, 5'h01};
        repeat (20) @(posedge mclk_i);
        $display("test chain rings done");
        do_reset();
        chk_on = 1'b0;
        @(posedge mclk_i);
        sel <= {8{5'h04}};
        cnt <= '0;
        spec <= '0;
        ce1 <= 1'b1;
        cej <= 1'b1;
        for (int c = 4; c < 7; c += 2) begin
            for (int b = 0; b < 2; b++) begin
                for (int m = 0; m < 4; m++) begin
                    if (!(b == 1 && m == 3)) begin
                        spec_case(c, b ? SEL_SPEC_B : SEL_SPEC_A, 2'(m));
                    end
                end
            end
        end
        @(posedge mclk_i);
        sel <= {8{5'h04}};
        repeat (3) @(posedge mclk_i);
        chk_on = 1'b1;
        rand_phase(100);
        final_report();
    end
endmodule
`default_nettype wire
